// ==== hdl/mtwsp_walker.sv ====
// table walker: descriptor status updates, protection, alternate-space path
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RL1: plain walk accesses write-through, no allocate
// RL2: locked accesses noncachable, push and invalidate
// RL3: lock only during locked descriptor updates
// RL4: check every descriptor used flag, set if clear
// RL5: modified set only without protect or violation
// RL6: flag updates finish before entry is released
// RL7: table descriptor written only when used clear
// RL8: used clear page without modified update gets locked read-modify-write
// RL9: unprotected write, modified clear: plain write
// RL10: accumulated protect blocks modified update
// RL11: alternate-space address passes through untranslated
// RL12: instruction codes 110/010 become 101/001
// RL13: error frame reports converted code and type
// RL14: software invalidates instruction line before move
// RL15: supervisor walks use supervisor tree base
// RL16: user hitting supervisor page blocks modified update, flags entry
// RL17: any protect flag marks entry write-protected
// RL18: resident only without invalid or bus error
// RL19: lock held from locked read through write
module mtwsp_walker
  import mtwsp_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // avalon-mm register slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  // walk request from the translation cache
  input wire logic walk_req_in,
  input wire logic [31:0] walk_la_in,
  input wire logic walk_super_in,
  input wire logic walk_write_in,
  output logic walk_busy_out,
  output logic entry_valid_out,
  output logic [19:0] entry_pa_out,
  output logic entry_wp_out,
  output logic entry_sup_out,
  output logic entry_mod_out,
  output logic entry_res_out,
  output logic entry_fc2_out,
  // walker memory port toward data cache and bus
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  output logic [1:0] mem_cm_out,
  output logic mem_push_inval_out,
  output logic mem_lock_out,
  input wire logic [31:0] mem_rdata_in,
  input wire logic mem_ack_in,
  input wire logic mem_err_in,
  // alternate-space alternate_space_move from the integer unit
  input wire logic acc_valid_in,
  input wire logic [31:0] acc_la_in,
  input wire logic [2:0] acc_fc_in,
  input wire logic acc_err_in,
  output logic acc_valid_out,
  output logic [31:0] acc_pa_out,
  output logic [2:0] acc_fc_out
);
  mtwsp_state_type state_q;
  logic [1:0] level_q;
  logic [31:0] la_q;
  logic super_q;
  logic write_q;
  logic wp_acc_q;
  logic [31:0] desc_q;
  logic [31:0] sup_base_q;
  logic [31:0] user_base_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [4:0] frame_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [2:0] map_fc;
  logic [1:0] map_xtype;
  logic bus_req;
  logic wr_hit;
  logic [2:0] w1c;
  logic finish;
  logic fault_evt;
  // evaluation of the descriptor just returned
  logic d_res;
  logic d_wp_tot;
  logic d_viol;
  logic d_set_mod;
  logic [31:0] d_next_addr;
  logic [6:0] ptr_idx;
  logic [5:0] pg_idx;

  mtwsp_fc_map u_fc_map (
    .fc_in(acc_fc_in),
    .fc_out(map_fc),
    .xtype_out(map_xtype)
  );

  assign ptr_idx = la_q[LA_ROOT_LO-1:LA_PTR_LO];
  assign pg_idx = la_q[LA_PTR_LO-1:LA_PAGE_LO];

  // descriptor decode; user hitting a supervisor page counts as a violation
  always_comb begin
    d_res = mem_rdata_in[DSC_RESIDENT];
    d_wp_tot = wp_acc_q | mem_rdata_in[DSC_WP];
    d_viol = ~super_q & mem_rdata_in[DSC_SUP];
    d_set_mod = write_q & ~d_wp_tot & ~d_viol & ~mem_rdata_in[DSC_MOD]; // RL5 RL10
    if (level_q == 2'h0) begin
      d_next_addr = {mem_rdata_in[31:DSC_TBL_LO], ptr_idx, 2'b00};
    end else begin
      d_next_addr = {mem_rdata_in[31:DSC_TBL_LO - 1], pg_idx, 2'b00};
    end
  end

  // walk sequencer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      level_q <= 2'h0;
      la_q <= 32'h0000_0000;
      super_q <= 1'b0;
      write_q <= 1'b0;
      wp_acc_q <= 1'b0;
      desc_q <= 32'h0000_0000;
      mem_addr_out <= 32'h0000_0000;
      mem_wdata_out <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (walk_req_in) begin
            la_q <= walk_la_in;
            super_q <= walk_super_in;
            write_q <= walk_write_in;
            wp_acc_q <= 1'b0;
            level_q <= 2'h0;
            // supervisor tree for supervisor walks, user tree otherwise
            if (walk_super_in) begin // RL15
              mem_addr_out <= {sup_base_q[31:DSC_TBL_LO], walk_la_in[31:LA_ROOT_LO], 2'b00};
            end else begin
              mem_addr_out <= {user_base_q[31:DSC_TBL_LO], walk_la_in[31:LA_ROOT_LO], 2'b00};
            end
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_ack_in) begin
            desc_q <= mem_rdata_in;
            if (mem_err_in || !d_res) begin
              state_q <= ST_DONE;
            end else if (level_q != LVL_PAGE) begin
              wp_acc_q <= d_wp_tot; // RL17
              if (!mem_rdata_in[DSC_USED]) begin
                // table descriptor written only to set a clear used flag
                mem_wdata_out <= mem_rdata_in | (32'h1 << DSC_USED); // RL4 RL7
                state_q <= ST_TBL_WR;
              end else begin
                mem_addr_out <= d_next_addr;
                level_q <= level_q + 2'h1;
              end
            end else begin
              wp_acc_q <= d_wp_tot; // RL17
              if (d_set_mod) begin
                // unprotected write with modified clear: plain write of both flags
                mem_wdata_out <= mem_rdata_in | (32'h1 << DSC_USED) | (32'h1 << DSC_MOD); // RL9
                state_q <= ST_PG_WR;
              end else if (!mem_rdata_in[DSC_USED]) begin
                state_q <= ST_PG_LOCK_RD; // RL8
              end else begin
                state_q <= ST_DONE; // RL10
              end
            end
          end
        end
        ST_TBL_WR: begin
          if (mem_ack_in) begin
            if (mem_err_in) begin
              state_q <= ST_DONE;
            end else begin
              mem_addr_out <= d_next_addr_tbl(desc_q, level_q, ptr_idx, pg_idx);
              level_q <= level_q + 2'h1;
              state_q <= ST_FETCH;
            end
          end
        end
        ST_PG_LOCK_RD: begin
          if (mem_ack_in) begin
            if (mem_err_in) begin
              state_q <= ST_DONE;
            end else begin
              // set used, keep modified as read back under the lock
              desc_q <= mem_rdata_in;
              mem_wdata_out <= mem_rdata_in | (32'h1 << DSC_USED); // RL8
              state_q <= ST_PG_LOCK_WR; // RL19
            end
          end
        end
        ST_PG_LOCK_WR, ST_PG_WR: begin
          if (mem_ack_in) begin
            if (!mem_err_in) begin
              desc_q <= mem_wdata_out;
            end
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // next table address from a stored table descriptor
  function automatic logic [31:0] d_next_addr_tbl(input logic [31:0] d, input logic [1:0] lvl,
                                                  input logic [6:0] pi, input logic [5:0] gi);
    logic [31:0] a;
    if (lvl == 2'h0) begin
      a = {d[31:DSC_TBL_LO], pi, 2'b00};
    end else begin
      a = {d[31:DSC_TBL_LO - 1], gi, 2'b00};
    end
    return a;
  endfunction

  // memory port strobes; lock and noncachable only for the locked pair
  always_comb begin
    mem_req_out = (state_q == ST_FETCH) || (state_q == ST_TBL_WR) || (state_q == ST_PG_WR)
                  || (state_q == ST_PG_LOCK_RD) || (state_q == ST_PG_LOCK_WR);
    mem_we_out = (state_q == ST_TBL_WR) || (state_q == ST_PG_WR) || (state_q == ST_PG_LOCK_WR);
    mem_lock_out = (state_q == ST_PG_LOCK_RD) || (state_q == ST_PG_LOCK_WR); // RL3 RL19
    mem_cm_out = mem_lock_out ? CM_NONCACHE : CM_WT_NOALLOC; // RL1 RL2
    mem_push_inval_out = mem_lock_out; // RL2
  end

  assign walk_busy_out = (state_q != ST_IDLE);
  assign finish = (state_q == ST_DONE);

  // entry is only released after every update write has been acknowledged
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      entry_valid_out <= 1'b0;
      entry_pa_out <= 20'h0_0000;
      entry_wp_out <= 1'b0;
      entry_sup_out <= 1'b0;
      entry_mod_out <= 1'b0;
      entry_res_out <= 1'b0;
      entry_fc2_out <= 1'b0;
    end else begin
      entry_valid_out <= finish; // RL6
      if (finish) begin
        entry_pa_out <= desc_q[31:DSC_PAGE_LO];
        entry_wp_out <= wp_acc_q; // RL17
        entry_sup_out <= desc_q[DSC_SUP] && (level_q == LVL_PAGE); // RL16
        entry_mod_out <= desc_q[DSC_MOD];
        entry_fc2_out <= super_q;
      end
      if (state_q != ST_IDLE && mem_ack_in && mem_err_in) begin
        entry_res_out <= 1'b0; // RL18
      end else if (state_q == ST_FETCH && mem_ack_in) begin
        entry_res_out <= d_res; // RL18
      end
    end
  end

  // alternate-space path: address used as physical, code remapped
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_valid_out <= 1'b0;
      acc_pa_out <= 32'h0000_0000;
      acc_fc_out <= 3'h0;
    end else begin
      acc_valid_out <= acc_valid_in;
      if (acc_valid_in) begin
        acc_pa_out <= acc_la_in; // RL11
        acc_fc_out <= map_fc; // RL12
      end
    end
  end

  // error frame: converted code and transfer type of the faulting move
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      frame_q <= 5'h00;
    end else if (acc_err_in) begin
      frame_q <= {map_xtype, map_fc}; // RL13
    end
  end

  // avalon slave: one wait state so read data leave a flip-flop
  assign bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign wr_hit = avs_write_in & ack_q;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (avs_read_in && !ack_q) begin
        case (avs_address_in)
          OFS_SUP_BASE: rdata_q <= sup_base_q;
          OFS_USER_BASE: rdata_q <= user_base_q;
          OFS_STATUS: rdata_q <= {29'h0, status_q};
          OFS_MASK: rdata_q <= {29'h0, mask_q};
          OFS_FRAME: rdata_q <= {27'h0, frame_q};
          OFS_ENTRY: rdata_q <= {entry_pa_out, 6'h00, entry_fc2_out, entry_res_out,
                                 entry_mod_out, entry_sup_out, entry_wp_out, walk_busy_out};
          default: rdata_q <= 32'h0000_0000; // unmapped reads as zero
        endcase
      end
    end
  end
  assign avs_readdata_out = rdata_q;

  // tree base and mask registers; a walk reads the bases only at start
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sup_base_q <= RST_TREE_BASE;
      user_base_q <= RST_TREE_BASE;
      mask_q <= RST_MASK;
    end else if (wr_hit) begin
      case (avs_address_in)
        OFS_SUP_BASE: sup_base_q <= avs_writedata_in;
        OFS_USER_BASE: user_base_q <= avs_writedata_in;
        OFS_MASK: mask_q <= avs_writedata_in[2:0];
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  assign fault_evt = entry_valid_out & ~entry_res_out;
  assign w1c = (wr_hit && avs_address_in == OFS_STATUS) ? avs_writedata_in[2:0] : 3'h0;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      status_q <= RST_STATUS;
    end else begin
      status_q <= (status_q & ~w1c) | {acc_err_in, fault_evt, entry_valid_out};
    end
  end
  assign irq_out = |(status_q & mask_q);

  // checks
  AST_LOCK_NONCACHE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL3
    mem_lock_out |-> (mem_req_out && mem_cm_out == CM_NONCACHE && mem_push_inval_out))
    else $error("lock seen outside a noncachable locked update");
  AST_PLAIN_WT: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL1
    (mem_req_out && !mem_lock_out) |-> (mem_cm_out == CM_WT_NOALLOC && !mem_push_inval_out))
    else $error("plain walk access not write-through");
  AST_LOCK_HELD: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL19
    (mem_lock_out && !mem_we_out && mem_ack_in && !mem_err_in) |=> (mem_lock_out && mem_we_out))
    else $error("lock dropped between locked read and write");
  AST_TBL_WR_ONLY_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL7
    (state_q == ST_TBL_WR) |-> (!desc_q[DSC_USED] && mem_wdata_out[DSC_USED]))
    else $error("table descriptor written although used was set");
  AST_PLAIN_WR_FLAGS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL9
    (state_q == ST_PG_WR) |-> (write_q && !wp_acc_q && mem_wdata_out[DSC_MOD]
                               && mem_wdata_out[DSC_USED] && !mem_lock_out))
    else $error("bad plain page descriptor write");
  AST_LOCK_KEEPS_MOD: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL8
    (state_q == ST_PG_LOCK_WR) |-> (mem_wdata_out[DSC_MOD] == desc_q[DSC_MOD]
                                    && mem_wdata_out[DSC_USED]))
    else $error("locked update changed modified flag");
  AST_ERR_NOT_RES: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL18
    (mem_req_out && mem_ack_in && mem_err_in) |-> ##2 (entry_valid_out && !entry_res_out))
    else $error("bus error walk produced resident entry");
  AST_NO_INSN_CODE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL12
    acc_valid_out |-> (acc_fc_out[1:0] != 2'b10 && acc_pa_out == $past(acc_la_in)))
    else $error("instruction code or translated address on move path");
  AST_FRAME_XTYPE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL13
    acc_err_in |=> (frame_q[4:3] == ((frame_q[1:0] == 2'b00 || frame_q[1:0] == 2'b11)
                                     ? XTYPE_ALT : XTYPE_NORMAL)))
    else $error("error frame transfer type wrong");
  AST_DONE_QUIET: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL6
    entry_valid_out |-> (!mem_req_out && !$past(mem_req_out)))
    else $error("entry released while an update was pending");
endmodule
`default_nettype wire

// ==== hdl/mtwsp_pkg.sv ====
// package: constants, descriptor layout and states of the table walker
package mtwsp_pkg;
  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_SUP_BASE = 8'h00;
  localparam logic [7:0] OFS_USER_BASE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_FRAME = 8'h10;
  localparam logic [7:0] OFS_ENTRY = 8'h14;
  // reset values
  localparam logic [31:0] RST_TREE_BASE = 32'h0000_0000;
  localparam logic [2:0] RST_STATUS = 3'h0;
  localparam logic [2:0] RST_MASK = 3'h0;
  // status / mask bit positions
  localparam int ST_WALK_DONE = 0;
  localparam int ST_WALK_FAULT = 1;
  localparam int ST_ACC_ERR = 2;
  // descriptor fields
  localparam int DSC_TYPE_HI = 1;
  localparam int DSC_RESIDENT = 1;
  localparam int DSC_WP = 2;
  localparam int DSC_USED = 3;
  localparam int DSC_MOD = 4;
  localparam int DSC_SUP = 7;
  localparam int DSC_TBL_LO = 9;
  localparam int DSC_PAGE_LO = 12;
  // logical address split: root, pointer, page index
  localparam int LA_ROOT_LO = 25;
  localparam int LA_PTR_LO = 18;
  localparam int LA_PAGE_LO = 12;
  localparam logic [1:0] LVL_PAGE = 2'h2;
  // cache mode presented with each walker access
  localparam logic [1:0] CM_WT_NOALLOC = 2'h0;
  localparam logic [1:0] CM_NONCACHE = 2'h3;
  // function codes
  localparam logic [2:0] FC_USER_PROG = 3'h2;
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_SUP_PROG = 3'h6;
  localparam logic [2:0] FC_SUP_DATA = 3'h5;
  localparam logic [1:0] XTYPE_NORMAL = 2'h0;
  localparam logic [1:0] XTYPE_ALT = 2'h2;
  typedef enum {
    ST_IDLE, ST_FETCH, ST_TBL_WR, ST_PG_LOCK_RD, ST_PG_LOCK_WR, ST_PG_WR, ST_DONE
  } mtwsp_state_type;
endpackage

// ==== hdl/mtwsp_fc_map.sv ====
// function-code remap for alternate-space alternate_space_move, with transfer type
`timescale 1ns/10ps
`default_nettype none
module mtwsp_fc_map
  import mtwsp_pkg::*;
(
  input wire logic [2:0] fc_in,
  output logic [2:0] fc_out,
  output logic [1:0] xtype_out
);
  // instruction spaces fold onto data spaces of the same privilege
  always_comb begin
    case (fc_in)
      FC_SUP_PROG: fc_out = FC_SUP_DATA;
      FC_USER_PROG: fc_out = FC_USER_DATA;
      default: fc_out = fc_in;
    endcase
  end
  // codes 000, 011, 100, 111 report the alternate transfer type
  always_comb begin
    case (fc_in)
      3'h0, 3'h3, 3'h4, 3'h7: xtype_out = XTYPE_ALT;
      default: xtype_out = XTYPE_NORMAL;
    endcase
  end
endmodule
`default_nettype wire

// ==== tb/mtwsp_mem_model.sv ====
// memory and arbiter stand-in that answers the walker's descriptor accesses
`timescale 1ns/10ps
`default_nettype none
module mtwsp_mem_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [1:0] delay_in,
  input wire logic err_en_in,
  input wire logic [31:0] err_addr_in,
  output logic [31:0] rdata_out,
  output logic ack_out,
  output logic err_out
);
  logic [31:0] words [0:1023];
  logic [1:0] cnt_q;
  // plain always: the bench preloads words between walks
  // read data is scrambled outside the ack cycle so stale values never pass
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_q <= 2'h0;
      ack_out <= 1'h0;
      err_out <= 1'h0;
      rdata_out <= 32'hFFFF_FFFF;
    end else if (ack_out) begin
      ack_out <= 1'h0;
      err_out <= 1'h0;
      cnt_q <= 2'h0;
      rdata_out <= ~rdata_out;
    end else if (req_in && cnt_q >= delay_in) begin
      ack_out <= 1'h1;
      err_out <= err_en_in && (addr_in == err_addr_in);
      if (!we_in) begin
        rdata_out <= words[addr_in[11:2]];
      end else if (!(err_en_in && addr_in == err_addr_in)) begin
        words[addr_in[11:2]] <= wdata_in;
      end
    end else begin
      cnt_q <= req_in ? cnt_q + 2'h1 : 2'h0;
      rdata_out <= ~rdata_out;
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_mtwsp_walker.sv ====
// self-checking bench for the table walker, its flag updates and move path
`timescale 1ns/10ps
`default_nettype none
module test_mtwsp_walker;
  import mtwsp_pkg::*;
  // row: {sup,wr,table_wp,bus_err} page, page after, {writes,locked}, {wp,mod,res}
  typedef struct packed {
    logic sup, wr, twp, err;
    logic [7:0] pg, pg_exp;
    logic [1:0] nwr, nlk;
    logic ewp, emod, eres;
  } mtwsp_row_type;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'h0, avs_write_in = 1'h0, avs_waitrequest_out, irq_out;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd, err_addr = 32'h0;
  logic walk_req_in = 1'h0, walk_super_in = 1'h0, walk_write_in = 1'h0, walk_busy_out;
  logic [31:0] walk_la_in = 32'h0, mem_addr_out, mem_wdata_out, mem_rdata_in;
  logic entry_valid_out, entry_wp_out, entry_sup_out, entry_mod_out, entry_res_out;
  logic entry_fc2_out, mem_req_out, mem_we_out, mem_push_inval_out, mem_lock_out;
  logic [19:0] entry_pa_out;
  logic [1:0] mem_cm_out, dly = 2'h0, xtype;
  logic mem_ack_in, mem_err_in, acc_valid_out, err_en = 1'h0, lk_rd = 1'h0;
  logic acc_valid_in = 1'h0, acc_err_in = 1'h0;
  logic [31:0] acc_la_in = 32'h0, acc_pa_out;
  logic [2:0] acc_fc_in = 3'h0, acc_fc_out, fe;
  int err_count = 0, n_compared = 0, n_wr = 0, n_lk = 0;
  mtwsp_row_type rows [0:15];

  mtwsp_walker uut (.clk_sys_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out, .walk_req_in,
    .walk_la_in, .walk_super_in, .walk_write_in, .walk_busy_out, .entry_valid_out,
    .entry_pa_out, .entry_wp_out, .entry_sup_out, .entry_mod_out, .entry_res_out,
    .entry_fc2_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_cm_out,
    .mem_push_inval_out, .mem_lock_out, .mem_rdata_in, .mem_ack_in, .mem_err_in,
    .acc_valid_in, .acc_la_in, .acc_fc_in, .acc_err_in, .acc_valid_out, .acc_pa_out,
    .acc_fc_out);
  mtwsp_mem_model mem (.clk_sys_in, .rst_in, .req_in(mem_req_out), .we_in(mem_we_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .delay_in(dly), .err_en_in(err_en),
    .err_addr_in(err_addr), .rdata_out(mem_rdata_in), .ack_out(mem_ack_in),
    .err_out(mem_err_in));

  always #20 clk_sys_in = ~clk_sys_in;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'h0 && n < 50);
    if (n >= 50) err_count++;
    rd = avs_readdata_out;
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
  endtask

  // preload both trees, the unused tree's page invalid, then walk logical address 0
  task automatic walk(input mtwsp_row_type r);
    int n;
    n = 0;
    mem.words[10'h000] = 32'h0000_0202;
    mem.words[10'h080] = r.twp ? 32'h0000_040E : 32'h0000_040A;
    mem.words[10'h200] = 32'h0000_0A02;
    mem.words[10'h280] = r.twp ? 32'h0000_0C0E : 32'h0000_0C0A;
    mem.words[10'h100] = r.sup ? {20'hABCDE, 4'h0, r.pg} : 32'h0;
    mem.words[10'h300] = r.sup ? 32'h0 : {20'hABCDE, 4'h0, r.pg};
    n_wr = 0;
    n_lk = 0;
    err_en <= r.err;
    err_addr <= r.sup ? 32'h400 : 32'hC00;
    walk_super_in <= r.sup;
    walk_write_in <= r.wr;
    walk_req_in <= 1'h1;
    @(posedge clk_sys_in);
    walk_req_in <= 1'h0;
    // request taken in idle, so the walker is busy from here on
    #1 chk({31'h0, walk_busy_out}, 32'h1);
    while (entry_valid_out !== 1'h1 && n < 200) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 200) err_count++;
    chk(mem.words[r.sup ? 10'h100 : 10'h300], {20'hABCDE, 4'h0, r.pg_exp});
    chk(32'(n_wr), {30'h0, r.nwr});
    chk(32'(n_lk), {30'h0, r.nlk});
    chk({28'h0, walk_busy_out, entry_res_out, entry_sup_out, entry_fc2_out},
        {28'h0, 1'h0, r.eres, r.pg[7], r.sup});
    if (r.eres) chk({10'h0, entry_pa_out, entry_wp_out, entry_mod_out},
                    {10'h0, 20'hABCDE, r.ewp, r.emod});
  endtask

  // every walker access: cache mode follows the lock; lock spans read to write
  always @(posedge clk_sys_in) begin
    if (lk_rd) chk({31'h0, mem_lock_out}, 32'h1);
    lk_rd = mem_req_out && mem_ack_in && mem_lock_out && !mem_we_out;
    if (mem_req_out === 1'h1 && mem_ack_in === 1'h1) begin
      if (mem_we_out) n_wr++;
      if (mem_lock_out) n_lk++;
      chk({29'h0, mem_cm_out, mem_push_inval_out},
          mem_lock_out ? {29'h0, CM_NONCACHE, 1'h1} : {29'h0, CM_WT_NOALLOC, 1'h0});
    end
  end

  initial begin
    rows = '{{4'h8, 8'h02, 8'h0A, 4'hA, 3'h1}, {4'h8, 8'h12, 8'h1A, 4'hA, 3'h3},
      {4'h8, 8'h0A, 8'h0A, 4'h4, 3'h1}, {4'h8, 8'h1A, 8'h1A, 4'h4, 3'h3},
      {4'hC, 8'h02, 8'h1A, 4'h8, 3'h3}, {4'hC, 8'h12, 8'h1A, 4'hA, 3'h3},
      {4'hC, 8'h0A, 8'h1A, 4'h8, 3'h3}, {4'hC, 8'h1A, 8'h1A, 4'h4, 3'h3},
      {4'hE, 8'h02, 8'h0A, 4'hA, 3'h5}, {4'hE, 8'h12, 8'h1A, 4'hA, 3'h7},
      {4'hE, 8'h0A, 8'h0A, 4'h4, 3'h5}, {4'hE, 8'h1A, 8'h1A, 4'h4, 3'h7},
      {4'hC, 8'h06, 8'h0E, 4'hA, 3'h5}, {4'h4, 8'h82, 8'h8A, 4'hA, 3'h1},
      {4'h8, 8'h00, 8'h00, 4'h4, 3'h0}, {4'h9, 8'h02, 8'h02, 4'h4, 3'h0}};
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    bus(1'h0, OFS_SUP_BASE, 32'h0);
    chk(rd, RST_TREE_BASE);
    bus(1'h0, OFS_MASK, 32'h0);
    chk(rd, {29'h0, RST_MASK});
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rd, {29'h0, RST_STATUS});
    bus(1'h1, OFS_USER_BASE, 32'h800);
    bus(1'h0, OFS_USER_BASE, 32'h0);
    chk(rd, 32'h800);
    // table rows, answering promptly and slowly in turn
    for (int i = 0; i < 16; i++) begin
      dly <= 2'(i % 3);
      walk(rows[i]);
    end
    // mid-run reset: walk result and registers fall back to reset values
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    #1 chk({28'h0, entry_valid_out, entry_res_out, walk_busy_out, irq_out}, 32'h0);
    bus(1'h0, OFS_USER_BASE, 32'h0);
    chk(rd, RST_TREE_BASE);
    // interrupt: clear, raise while masked, unmask, clear again
    bus(1'h1, OFS_STATUS, 32'h7);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    walk(rows[2]);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[ST_WALK_DONE], irq_out}, 32'h2);
    bus(1'h1, OFS_MASK, 32'h1);
    #1 chk({31'h0, irq_out}, 32'h1);
    bus(1'h1, OFS_STATUS, 32'h1);
    #1 chk({31'h0, irq_out}, 32'h0);
    bus(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // every move code, each one faulting
    for (int f = 0; f < 8; f++) begin
      fe = (f == 6) ? FC_SUP_DATA : (f == 2) ? FC_USER_DATA : 3'(f);
      xtype = (f == 0 || f == 3 || f == 4 || f == 7) ? XTYPE_ALT : XTYPE_NORMAL;
      @(posedge clk_sys_in);
      acc_valid_in <= 1'h1;
      acc_err_in <= 1'h1;
      // the bench caches no instruction lines, so no invalidate precedes a move
      acc_fc_in <= 3'(f);
      acc_la_in <= 32'h1234_5670 + 32'(f);
      @(posedge clk_sys_in);
      acc_valid_in <= 1'h0;
      acc_err_in <= 1'h0;
      #1 chk({28'h0, acc_valid_out, acc_fc_out}, {28'h0, 1'h1, fe});
      chk(acc_pa_out, 32'h1234_5670 + 32'(f));
      bus(1'h0, OFS_FRAME, 32'h0);
      chk(rd, {27'h0, xtype, fe});
    end
    bus(1'h0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_ACC_ERR]}, 32'h1);
    results;
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    results;
  end
endmodule
`default_nettype wire
